// *** bench/flyback_pwm_timing_core_properties.sv ***
// concurrent checks on the ports of the flyback pwm timing core
`timescale 1ns/100ps
`default_nettype none
module flyback_pwm_timing_core_properties (
   input wire logic sys_clk,                    // system clock
   input wire logic rst_b,                      // async reset, active low
   input wire logic supply_above_short,         // supply above short threshold
   input wire logic supply_above_on,            // supply above turn-on threshold
   input wire logic burst_mode,                 // burst mode
   input wire logic in_regulation,              // output regulated
   input wire flyback_pkg::sense_t sense,       // sense codes
   input wire logic first_step_charge_current,  // small source on
   input wire logic second_step_charge_current, // large source on
   input wire logic gate_on,                    // gate command
   input wire logic gate_soft_rise,             // slow edge phase
   input wire logic soft_start_active,          // soft start
   input wire logic [1:0] soft_step             // soft-start step
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   logic gate_q;
   logic seen;
   logic [1:0] step_q;
   logic [9:0] on_cnt;
   logic [9:0] per_cnt;
   logic [16:0] step_cnt;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_q <= 1'b0;
         seen <= 1'b0;
         step_q <= 2'h0;
         on_cnt <= 10'h000;
         per_cnt <= 10'h000;
         step_cnt <= 17'h00000;
      end else begin
         gate_q <= gate_on;
         seen <= seen | (gate_on & ~gate_q);
         step_q <= soft_step;
         on_cnt <= gate_on ? on_cnt + 10'h001 : 10'h000;
         per_cnt <= (gate_on & ~gate_q) ? 10'h001 : per_cnt + 10'h001;
         step_cnt <= (!soft_start_active || soft_step != step_q) ? 17'h00000 : step_cnt + 17'h00001;
      end
   end
   sequence s_rise;
      $rose(gate_on);
   endsequence
   sequence s_step;
      $changed(soft_step);
   endsequence
   property p_charge_excl;
      !(first_step_charge_current && second_step_charge_current);
   endproperty
   property p_charge_order;
      $rose(second_step_charge_current) |-> $past(first_step_charge_current) && $past(supply_above_short, 2);
   endproperty
   property p_soft_entry;
      $rose(soft_start_active) |-> $past(second_step_charge_current) && $past(supply_above_on, 2) && soft_step == 2'h0;
   endproperty
   property p_no_gate_precharge;
      (first_step_charge_current || second_step_charge_current) |-> !gate_on;
   endproperty
   property p_min_on;
      s_rise |-> gate_on [*8];
   endproperty
   property p_max_on;
      on_cnt <= 10'd384;
   endproperty
   property p_period;
      s_rise and seen |-> per_cnt inside {[10'd239:10'd512]};
   endproperty
   property p_step_order;
      s_step |-> soft_start_active && soft_step == $past(soft_step) + 2'h1;
   endproperty
   property p_step_len;
      s_step |-> step_cnt inside {[flyback_pkg::STEP_CYCLES - 8:flyback_pkg::STEP_CYCLES + 8]};
   endproperty
   property p_soft_rise;
      s_rise |-> ##[0:1] (gate_soft_rise && gate_on);
   endproperty
   property p_rise_in_pulse;
      gate_soft_rise |-> gate_on;
   endproperty
   a_charge_excl: assert property (p_charge_excl) else $error("both charge sources on");
   a_charge_order: assert property (p_charge_order) else $error("second step out of order");
   a_soft_entry: assert property (p_soft_entry) else $error("soft start entered wrongly");
   a_no_gate_precharge: assert property (p_no_gate_precharge) else $error("gate during charge");
   a_min_on: assert property (p_min_on) else $error("pulse shorter than blanking");
   a_max_on: assert property (p_max_on) else $error("pulse beyond duty limit");
   a_period: assert property (p_period) else $error("switching period out of range");
   a_step_order: assert property (p_step_order) else $error("soft step jumped");
   a_step_len: assert property (p_step_len) else $error("soft step length wrong");
   a_soft_rise: assert property (p_soft_rise) else $error("gate edge not slowed");
   a_rise_in_pulse: assert property (p_rise_in_pulse) else $error("slow rise outside pulse");
endmodule // flyback_pwm_timing_core_properties
bind flyback_pwm_timing_core flyback_pwm_timing_core_properties u_props (.sys_clk, .rst_b,
   .supply_above_short, .supply_above_on, .burst_mode, .in_regulation, .sense,
   .first_step_charge_current, .second_step_charge_current, .gate_on, .gate_soft_rise,
   .soft_start_active, .soft_step);
`default_nettype wire

// *** bench/switch_model.sv ***
// behavioural power switch and sense resistor driven from the gate command
`timescale 1ns/100ps
`default_nettype none
module switch_model (
   input wire logic sys_clk,        // system clock
   input wire logic gate_on,        // gate command from the core
   input wire logic [9:0] rate,     // sense code rise per cycle while on
   output logic [9:0] cs_code       // current-sense code
);
   // ----------------------------------------
   // primary current ramp
   // ----------------------------------------
   logic [10:0] next_cs;
   assign next_cs = {1'b0, cs_code} + {1'b0, rate};
   // current builds only while the switch conducts; off, the resistor pulls to ground
   always_ff @(posedge sys_clk) begin
      if (!gate_on) begin
         cs_code <= 10'h000;
      end else begin
         cs_code <= next_cs[10] ? 10'h3FF : next_cs[9:0];
      end
   end
endmodule // switch_model
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the flyback pwm timing core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic sys_clk;
   logic rst_b;
   logic supply_above_short;
   logic supply_above_on;
   logic burst_mode;
   logic in_regulation;
   logic [9:0] fb;
   logic [9:0] rate;
   logic [9:0] cs_code;
   logic first_step_charge_current;
   logic second_step_charge_current;
   logic gate_on;
   logic gate_soft_rise;
   logic soft_start_active;
   logic [1:0] soft_step;
   int bad_count;
   int n_checks;
   int cyc;
   int t0;
   int on_t;
   int per;
   int lo;
   int r;
   int f;
   int p;
   bit g;
   bit bm;
   // max duty, blanking, peak, clamp, feedback trip, slope, burst, floor
   int tr[8] = '{0, 1023, 1, 1, 1, 0, 0, 1};
   int tf[8] = '{10'h1A9, 10'h1A9, 10'h3FF, 10'h0FA, 10'h0FA, 10'h0FA, 10'h0FA, 10'h000};
   bit tg[8] = '{0, 0, 0, 0, 1, 1, 1, 0};
   bit tm[8] = '{1, 0, 0, 0, 0, 0, 1, 0};
   flyback_pwm_timing_core uut (.sys_clk, .rst_b, .supply_above_short, .supply_above_on,
      .burst_mode, .in_regulation, .sense(flyback_pkg::sense_t'({cs_code, fb})),
      .first_step_charge_current, .second_step_charge_current, .gate_on, .gate_soft_rise,
      .soft_start_active, .soft_step);
   switch_model u_sw (.sys_clk, .gate_on, .rate, .cs_code);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;
   // ----------------------------------------
   // checking and timing helpers
   // ----------------------------------------
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_near(input int got, input int low, input int span);
      n_checks++;
      if (got < low || got > low + span) begin
         bad_count++;
         $display("mismatch at %0t got %h expected from %h", $time, got, low);
      end
   endtask
   task automatic wait_gate(input logic lvl, output int n);
      n = 0;
      while (gate_on !== lvl) begin
         // sampled mid-cycle so the gate edge has settled
         @(negedge sys_clk);
         n++;
         if (n > 600) begin
            bad_count++;
            $display("mismatch at %0t gate stuck at %h expected %h", $time, gate_on, lvl);
            results();
         end
      end
   endtask
   // the first pulse after a change may still run on old inputs, so one is skipped
   task automatic measure(input int rv, input int fv, input bit rg, input bit bv);
      int n;
      @(posedge sys_clk);
      rate <= 10'(rv);
      fb <= 10'(fv);
      in_regulation <= rg;
      burst_mode <= bv;
      wait_gate(1'b1, n);
      wait_gate(1'b0, n);
      wait_gate(1'b1, n);
      wait_gate(1'b0, on_t);
      wait_gate(1'b1, n);
      per = on_t + n;
   endtask
   function automatic int exp_on(int rv, int fv, bit rg, bit bv, int pv);
      int cs;
      int sl;
      for (int k = 1; k < pv * 3 / 4; k++) begin
         cs = (k * rv > 1023) ? 1023 : k * rv;
         sl = (bv || k * 10 < pv * 4) ? 0 : (k - pv * 4 / 10) * flyback_pkg::SLOPE_RATE;
         if (k >= flyback_pkg::BLANK_CYCLES && (cs > flyback_pkg::CS_START_LIMIT ||
             (rg && cs * flyback_pkg::PWM_GAIN + flyback_pkg::PWM_OFFSET + sl > fv))) begin
            return k;
         end
      end
      return pv * 3 / 4;
   endfunction
   initial begin
      void'($urandom(32'h4BD851D1));
      rst_b = 1'b0;
      supply_above_short = 1'b0;
      supply_above_on = 1'b0;
      burst_mode = 1'b0;
      in_regulation = 1'b0;
      fb = 10'h1A9;
      rate = 10'h000;
      repeat (6) @(posedge sys_clk);
      chk({first_step_charge_current, gate_on, soft_start_active, soft_step}, 0);
      rst_b <= 1'b1;
      repeat (2 + $urandom_range(30)) @(posedge sys_clk);
      chk({first_step_charge_current, second_step_charge_current, gate_on}, 3'h4);
      supply_above_short <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk({first_step_charge_current, second_step_charge_current, soft_start_active}, 3'h2);
      supply_above_on <= 1'b1;
      t0 = cyc;
      repeat (6) @(posedge sys_clk);
      chk({second_step_charge_current, soft_start_active, soft_step}, 4'h4);
      for (int i = 0; i < 14; i++) begin
         r = (i < 8) ? tr[i] : 1 + $urandom_range(7);
         f = (i < 8) ? tf[i] : 10'h1A9 + $urandom_range(10'h256);
         g = (i < 8) ? tg[i] : 1'($urandom_range(1));
         bm = (i < 8) ? tm[i] : 1'($urandom_range(1));
         p = (f >= flyback_pkg::FB_REDUCE_LEVEL) ? flyback_pkg::NOMINAL_PERIOD : flyback_pkg::LONGEST_PERIOD;
         measure(r, f, g, bm);
         chk_near(on_t, exp_on(r, f, g, bm, p), 6);
         chk(per, p);
      end
      measure(1, 10'h150, 1'b0, 1'b0);
      chk(per > flyback_pkg::NOMINAL_PERIOD && per < flyback_pkg::LONGEST_PERIOD, 1);
      lo = per;
      measure(1, 10'h120, 1'b0, 1'b0);
      chk(per > lo, 1);
      while (cyc - t0 < flyback_pkg::STEP_CYCLES - 20) @(posedge sys_clk);
      chk(soft_step, 2'h0);
      for (int i = 0; i < 40 && soft_step !== 2'h1; i++) @(posedge sys_clk);
      chk_near(cyc - t0, flyback_pkg::STEP_CYCLES - 2, 10);
      chk({soft_start_active, soft_step}, 3'h5);
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({first_step_charge_current, gate_on, soft_start_active, soft_step}, 0);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk({first_step_charge_current, soft_start_active}, 2'h2);
      repeat (12) @(posedge sys_clk);
      chk({second_step_charge_current, soft_start_active, soft_step}, 4'h4);
      results();
   end
endmodule // tb_top
`default_nettype wire

// *** rtl/dither_sweep.sv ***
// triangular period dither generator
`timescale 1ns/100ps
`default_nettype none
module dither_sweep (
   input wire logic sys_clk,        // system clock
   input wire logic rst_b,          // async reset, active low
   input wire logic enable,         // dither allowed
   output logic [9:0] offset        // signed-free offset 0..2*span
);
   logic [31:0] tick;
   logic up;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick <= 32'h0;
         up <= 1'b1;
         offset <= flyback_pkg::JITTER_SPAN;
      end else if (!enable) begin
         tick <= 32'h0;
         offset <= flyback_pkg::JITTER_SPAN;
      end else if (tick >= 32'(flyback_pkg::JITTER_TICK - 1)) begin
         // full sweep of 4*span steps spans one jitter period
         tick <= 32'h0;
         if (up && offset >= 10'(2 * flyback_pkg::JITTER_SPAN)) begin
            up <= 1'b0;
            offset <= offset - 10'h001;
         end else if (!up && offset == 10'h000) begin
            up <= 1'b1;
            offset <= 10'h001;
         end else begin
            offset <= up ? offset + 10'h001 : offset - 10'h001;
         end
      end else begin
         tick <= tick + 32'h1;
      end
   end
endmodule // dither_sweep
`default_nettype wire

// *** rtl/flyback_pkg.sv ***
// shared constants and carrier types for the flyback pwm timing core
package flyback_pkg;
   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int SOFT_START_MS = 12;
   localparam int SOFT_START_STEPS = 4;
   localparam int STEP_CYCLES = (CLK_HZ / 1000) * SOFT_START_MS / SOFT_START_STEPS;
   localparam int JITTER_PERIOD_MS = 4;
   localparam int JITTER_CYCLES = (CLK_HZ / 1000) * JITTER_PERIOD_MS;
   localparam int NOMINAL_FREQ_HZ = 100000;
   localparam int MIN_FREQ_HZ = 50000;
   // period in cycles: 250 at 100 kHz, 500 at the lowest frequency
   localparam logic [9:0] NOMINAL_PERIOD = 10'(CLK_HZ / NOMINAL_FREQ_HZ);
   localparam logic [9:0] LONGEST_PERIOD = 10'(CLK_HZ / MIN_FREQ_HZ);
   localparam int BLANK_NS = 300;
   localparam logic [9:0] BLANK_CYCLES = 10'((BLANK_NS * 25 + 999) / 1000);
   // jitter amplitude is 4 percent of the nominal period
   localparam logic [9:0] JITTER_SPAN = 10'((CLK_HZ / NOMINAL_FREQ_HZ) * 4 / 100);
   localparam logic [9:0] JITTER_STEP_CYCLES_HALF = 10'(0);
   localparam int JITTER_TICK = JITTER_CYCLES / (4 * 10);
   // ---------------------------------------------------------------
   // analog codes: 10 bit, 1 lsb = 4 mV
   // ---------------------------------------------------------------
   localparam logic [9:0] CS_START_LIMIT = 10'h04B;  // 0.3 V
   localparam logic [9:0] CS_PEAK_LIMIT = 10'h0C8;   // 0.8 V
   localparam logic [9:0] CS_LIMIT_STEP = 10'h029;   // rise per step, last step clamps to peak
   localparam logic [9:0] FB_REDUCE_LEVEL = 10'h1A9; // 1.7 V
   localparam logic [9:0] FB_MIN_LEVEL = 10'h0FA;    // 1.0 V, lowest frequency reached
   localparam logic [3:0] PWM_GAIN = 4'h3;
   localparam logic [9:0] PWM_OFFSET = 10'h07D;      // 0.5 V
   localparam logic [9:0] SLOPE_RATE = 10'h001;      // codes per cycle
   localparam int DUTY_MAX_PCT = 75;
   localparam int SLOPE_START_PCT = 40;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum {ST_CHARGE1, ST_CHARGE2, ST_SOFT, ST_NORMAL} phase_t;
   typedef struct packed {
      logic [9:0] cs_code;   // current-sense pin voltage
      logic [9:0] fb_code;   // feedback voltage
   } sense_t;
endpackage

// *** rtl/flyback_pwm_timing_core.sv ***
// start-up sequencing and peak current mode pwm timing for the flyback controller
// Notes on behaviour
// - charge supply with tiny current to short threshold, then larger current to turn-on.
// - switching starts above turn-on threshold, always beginning in soft start.
// - soft start is digital, 12 ms long, in four equal steps.
// - peak current ceiling steps from 0.3 V up to 0.8 V.
// - at regulation, feedback loop takes over switch-off from soft-start ceiling.
// - each turn-on follows the oscillator; frequency depends on feedback voltage.
// - gate ends when scaled current signal exceeds feedback voltage.
// - current comparison ignored during blanking; blanking is minimum on-time.
// - gate forced off at 75 percent of the switching period.
// - scaled current signal equals sense voltage times gain plus offset.
// - full frequency at high load; reduction starts below 1.7 V feedback.
// - feedback never sets frequency below the lowest switch frequency; dither can lengthen that period by up to 10 cycles.
// - slope ramp added only beyond 40 percent on-time, growing with on-time.
// - slope compensation off in burst mode.
// - frequency dithers around nominal with a 4 ms cycle.
// - dither off in soft start, on in normal operation and reduction.
// - gate rise is slowed before the switch threshold is reached.
// - after blanking, gate ends when sense voltage exceeds the present peak limit.
`timescale 1ns/100ps
`default_nettype none
module flyback_pwm_timing_core (
   input wire logic sys_clk,                  // 25 MHz system clock
   input wire logic rst_b,                    // supply under-voltage reset, active low
   input wire logic supply_above_short,       // supply above supply_short_threshold
   input wire logic supply_above_on,          // supply above turn-on threshold
   input wire logic burst_mode,               // burst mode active, from outside
   input wire logic in_regulation,            // output has reached regulation
   input wire flyback_pkg::sense_t sense,     // digitised sense and feedback codes
   output logic first_step_charge_current,    // small pre-charge source on
   output logic second_step_charge_current,   // larger pre-charge source on
   output logic gate_on,                      // gate command
   output logic gate_soft_rise,               // slow-rise phase of the gate edge
   output logic soft_start_active,            // soft start in progress
   output logic [1:0] soft_step               // present soft-start step
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] short_sync, on_sync, burst_sync, reg_sync;
   flyback_pkg::sense_t sense_meta, sense_s;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         short_sync <= 2'h0;
         on_sync <= 2'h0;
         burst_sync <= 2'h0;
         reg_sync <= 2'h0;
         sense_meta <= '0;
         sense_s <= '0;
      end else begin
         short_sync <= {short_sync[0], supply_above_short};
         on_sync <= {on_sync[0], supply_above_on};
         burst_sync <= {burst_sync[0], burst_mode};
         reg_sync <= {reg_sync[0], in_regulation};
         sense_meta <= sense;
         sense_s <= sense_meta;
      end
   end
   logic short_ok, on_ok, burst, regulated;
   assign short_ok = short_sync[1];
   assign on_ok = on_sync[1];
   assign burst = burst_sync[1];
   assign regulated = reg_sync[1];

   // ---------------------------------------------------------------
   // start-up phase sequencer
   // ---------------------------------------------------------------
   flyback_pkg::phase_t phase;
   logic [31:0] step_count;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= flyback_pkg::ST_CHARGE1;
      end else begin
         case (phase)
            flyback_pkg::ST_CHARGE1: begin
               if (short_ok) begin
                  phase <= flyback_pkg::ST_CHARGE2;
               end
            end
            flyback_pkg::ST_CHARGE2: begin
               if (on_ok) begin
                  phase <= flyback_pkg::ST_SOFT;
               end
            end
            flyback_pkg::ST_SOFT: begin
               if (soft_step == 2'(flyback_pkg::SOFT_START_STEPS - 1) &&
                   step_count == 32'(flyback_pkg::STEP_CYCLES - 1)) begin
                  phase <= flyback_pkg::ST_NORMAL;
               end
            end
            flyback_pkg::ST_NORMAL: begin
               phase <= flyback_pkg::ST_NORMAL;
            end
            default: begin
               phase <= flyback_pkg::ST_CHARGE1;
            end
         endcase
      end
   end

   // equal-length steps of the digital soft start
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         step_count <= 32'h0;
         soft_step <= 2'h0;
      end else if (phase != flyback_pkg::ST_SOFT) begin
         step_count <= 32'h0;
      end else if (step_count == 32'(flyback_pkg::STEP_CYCLES - 1)) begin
         step_count <= 32'h0;
         if (soft_step != 2'(flyback_pkg::SOFT_START_STEPS - 1)) begin
            soft_step <= soft_step + 2'h1;
         end
      end else begin
         step_count <= step_count + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         first_step_charge_current <= 1'b0;
         second_step_charge_current <= 1'b0;
         soft_start_active <= 1'b0;
      end else begin
         first_step_charge_current <= phase == flyback_pkg::ST_CHARGE1;
         second_step_charge_current <= phase == flyback_pkg::ST_CHARGE2;
         soft_start_active <= phase == flyback_pkg::ST_SOFT;
      end
   end

   // ---------------------------------------------------------------
   // peak ceiling and dither
   // ---------------------------------------------------------------
   logic [9:0] ramp_ceiling;
   ramp_limit_table u_table (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .step(soft_step),
      .limit(ramp_ceiling)
   );

   logic switching, normal_run, dither_en;
   assign switching = phase == flyback_pkg::ST_SOFT || phase == flyback_pkg::ST_NORMAL;
   assign normal_run = phase == flyback_pkg::ST_NORMAL;
   assign dither_en = normal_run;

   logic [9:0] dither_offset;
   dither_sweep u_dither (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .enable(dither_en),
      .offset(dither_offset)
   );

   // soft-start ceiling holds until both the ramp is done and regulation is seen
   logic [9:0] peak_limit;
   assign peak_limit = (normal_run && regulated) ? flyback_pkg::CS_PEAK_LIMIT : ramp_ceiling;

   // ---------------------------------------------------------------
   // oscillator period from feedback
   // ---------------------------------------------------------------
   logic [9:0] base_period, period_target, period;
   logic [10:0] fb_drop;
   always_comb begin
      fb_drop = 11'h0;
      if (sense_s.fb_code >= flyback_pkg::FB_REDUCE_LEVEL) begin
         base_period = flyback_pkg::NOMINAL_PERIOD;
      end else if (sense_s.fb_code <= flyback_pkg::FB_MIN_LEVEL) begin
         base_period = flyback_pkg::LONGEST_PERIOD;
      end else begin
         // linear in period: 175 fb codes spread over 250 period cycles
         fb_drop = 11'(flyback_pkg::FB_REDUCE_LEVEL - sense_s.fb_code);
         base_period = 10'(flyback_pkg::NOMINAL_PERIOD +
            10'((fb_drop * 11'd10) / 11'd7));
      end
      period_target = 10'(base_period + dither_offset - flyback_pkg::JITTER_SPAN);
   end

   // ---------------------------------------------------------------
   // cycle counter and gate timing
   // ---------------------------------------------------------------
   logic [9:0] cyc, max_on, slope_start;
   logic cycle_end;
   assign cycle_end = cyc >= period - 10'h001;
   assign max_on = 10'((20'(period) * 20'(flyback_pkg::DUTY_MAX_PCT)) / 20'd100);
   assign slope_start = 10'((20'(period) * 20'(flyback_pkg::SLOPE_START_PCT)) / 20'd100);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cyc <= 10'h0;
         period <= flyback_pkg::NOMINAL_PERIOD;
      end else if (!switching || cycle_end) begin
         cyc <= 10'h0;
         period <= period_target;
      end else begin
         cyc <= cyc + 10'h001;
      end
   end

   // scaled current signal with slope ramp
   logic [13:0] scaled_current_signal, slope_add;
   always_comb begin
      slope_add = 14'h0;
      if (!burst && cyc > slope_start) begin
         slope_add = 14'((cyc - slope_start) * flyback_pkg::SLOPE_RATE);
      end
      scaled_current_signal = 14'(sense_s.cs_code * flyback_pkg::PWM_GAIN) +
         14'(flyback_pkg::PWM_OFFSET) + slope_add;
   end

   logic blanking, fb_trip, peak_trip, duty_trip;
   assign blanking = cyc < flyback_pkg::BLANK_CYCLES;
   assign fb_trip = regulated && scaled_current_signal > 14'(sense_s.fb_code);
   assign peak_trip = sense_s.cs_code > peak_limit;
   assign duty_trip = cyc >= max_on - 10'h001;

   logic next_gate;
   always_comb begin
      next_gate = gate_on;
      if (!switching) begin
         next_gate = 1'b0;
      end else if (cycle_end) begin
         next_gate = 1'b1;
      end else if (gate_on && duty_trip) begin
         next_gate = 1'b0;
      end else if (gate_on && !blanking && (fb_trip || peak_trip)) begin
         next_gate = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_on <= 1'b0;
      end else begin
         gate_on <= next_gate;
      end
   end

   // slow rise for the first four cycles of each pulse
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gate_soft_rise <= 1'b0;
      end else begin
         gate_soft_rise <= next_gate && (!gate_on || cyc < 10'h003);
      end
   end
endmodule // flyback_pwm_timing_core
`default_nettype wire

// *** rtl/ramp_limit_table.sv ***
// small memory of soft-start current ceilings, registered read
`timescale 1ns/100ps
`default_nettype none
module ramp_limit_table (
   input wire logic sys_clk,        // system clock
   input wire logic rst_b,          // async reset, active low
   input wire logic [1:0] step,     // soft-start step index
   output logic [9:0] limit         // registered ceiling code
);
   logic [9:0] table_mem [4];
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_entry
         assign table_mem[g] = (g == 3) ? flyback_pkg::CS_PEAK_LIMIT :
            10'(flyback_pkg::CS_START_LIMIT + 10'(g) * flyback_pkg::CS_LIMIT_STEP);
      end
   endgenerate
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         limit <= flyback_pkg::CS_START_LIMIT;
      end else begin
         limit <= table_mem[step];
      end
   end
endmodule // ramp_limit_table
`default_nettype wire
